// ==== design/rtc_pkg.sv ====
// Register map, field positions, reset values and timing for the RTC block.
// Assumes a 20 MHz core clock and a 32 kHz timebase on a pin.
package rtc_pkg;

	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  OFF_WHOLE       = 8'h00;
	localparam logic [7:0]  OFF_FRACTION    = 8'h04;
	localparam logic [7:0]  OFF_DAYTIME     = 8'h08;
	localparam logic [7:0]  OFF_INTERVAL    = 8'h0C;
	localparam logic [7:0]  OFF_CONTROL     = 8'h10;
	localparam logic [7:0]  OFF_CRYSTAL     = 8'h18;

	// Control register fields
	localparam int          CTL_RUN         = 0;
	localparam int          CTL_DAY_EN      = 1;
	localparam int          CTL_INT_EN      = 2;
	localparam int          CTL_BUSY        = 3;
	localparam int          CTL_READY       = 4;
	localparam int          CTL_READY_IE    = 5;
	localparam int          CTL_DAY_FLAG    = 6;
	localparam int          CTL_INT_FLAG    = 7;
	localparam int          CTL_WAVE_EN     = 8;
	localparam int          CTL_RATE_LO     = 9;
	localparam int          CTL_RATE_HI     = 10;
	localparam int          CTL_DIRECT_RD   = 14;
	localparam int          CTL_UNLOCK      = 15;

	// Crystal setup register fields
	localparam int          OSC_BYPASS      = 4;
	localparam int          OSC_CLK_OUT     = 5;
	localparam logic [3:0]  OSC_RSVD_RESET  = 4'h9;

	// Counter geometry
	localparam int          FRAC_W          = 12;
	localparam int          FRAC_LOW_W      = 8;
	localparam int          DAY_W           = 20;
	localparam logic [11:0] FRAC_LAST       = 12'hFFF;
	localparam logic [31:0] INTERVAL_LAST   = 32'hFFFFFFFF;

	// Square wave rate codes
	localparam logic [1:0]  RATE_1HZ        = 2'h0;
	localparam logic [1:0]  RATE_512HZ      = 2'h1;
	localparam logic [1:0]  RATE_4KHZ       = 2'h2;
	localparam int          FRAC_BIT_512HZ  = 2;

	// Timebase divider: 32 kHz down to the 4 kHz fraction step
	localparam int          OSC_DIV_W       = 3;

	// Timing
	localparam int          CLK_PERIOD_NS   = 50;
	localparam int          READY_TIME_NS   = 120000;
	localparam int          READY_CYCLES    = READY_TIME_NS / CLK_PERIOD_NS;
	localparam int          READY_CNT_W     = 12;

endpackage : rtc_pkg

// ==== design/rtc_timebase.sv ====
// Timebase: synchronises the crystal and external wave pins, selects the source
// and divides it to the 4 kHz fraction step. Pins are asynchronous.
`timescale 1ns/10ps
module rtc_timebase (
	input  wire logic                             mclk_in,
	input  wire logic                             rst_n_in,
	input  wire logic                             xtal_in,
	input  wire logic                             ext_wave_in,
	input  wire logic                             bypass_in,
	output logic                                  osc_level_out,
	output logic                                  div_level_out,
	output logic                                  step_out
);
	import rtc_pkg::*;

	logic [1:0]             xtal_sync_q;
	logic [1:0]             ext_sync_q;
	logic                   level_q;
	logic [OSC_DIV_W-1:0]   div_q;
	logic                   sel_d;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers, source chosen after them
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			xtal_sync_q <= 2'h0;
			ext_sync_q  <= 2'h0;
		end else begin
			xtal_sync_q <= {xtal_sync_q[0], xtal_in};
			ext_sync_q  <= {ext_sync_q[0], ext_wave_in};
		end
	end

	assign sel_d = bypass_in ? ext_sync_q[1] : xtal_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// Rising edge count, step on divider wrap
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			level_q <= 1'b0;
			div_q   <= '0;
		end else begin
			level_q <= sel_d;
			if (sel_d && !level_q) begin
				div_q <= div_q + 1'b1;
			end
		end
	end

	assign step_out      = sel_d && !level_q && (&div_q);
	assign osc_level_out = level_q;
	assign div_level_out = div_q[OSC_DIV_W-1];

endmodule : rtc_timebase

// ==== design/rtc_counter_alarm_regs.sv ====
// Real-time clock: seconds and fraction counters, two alarms, ready and
// busy status, square wave output. Registers over a peripheral bus.
// Assumes a 20 MHz clock and a synchronous active-high soft reset.
//
// Behaviour
// - 32-bit seconds count, software read and write
// - 12-bit fraction; low 8 writable, high 4 out
// - Fraction rollover advances the seconds count
// - 20-bit daytime match against seconds raises alarm
// - Interval counter reloads and alarms on wrap
// - Run bit writable only while unlocked
// - Soft reset clears unlock, ready, ready enable
// - Direct read bit is stored only; counter reads are always live
// - Rate field picks square wave frequency
// - Square wave driven when wave or clock-out enabled
// - Interval alarm sets flag and wakeup
// - Daytime match sets daytime flag
// - Ready held 120us after each update
// - Ready with enable raises clock interrupt
// - Busy set by sync writes, cleared after
// - Alarm enables gate alarm interrupts
// - Bypass disables crystal, uses external wave
// - Clock-out bit routes oscillator to pin
// - Fraction steps at 4 kHz
`timescale 1ns/10ps
module rtc_counter_alarm_regs (
	input  wire logic                             mclk_in,
	input  wire logic                             arst_n_in,
	input  wire logic                             soft_rst_in,
	input  wire logic                             psel_in,
	input  wire logic                             penable_in,
	input  wire logic                             pwrite_in,
	input  wire logic [rtc_pkg::ADDR_W-1:0]       paddr_in,
	input  wire logic [31:0]                      pwdata_in,
	input  wire logic                             xtal_in,
	input  wire logic                             osc_clock_in_pin_in,
	output logic [31:0]                           prdata_out,
	output logic                                  pready_out,
	output logic                                  pslverr_out,
	output logic                                  rtc_irq_out,
	output logic                                  wakeup_out,
	output logic                                  osc_clock_out,
	output logic                                  osc_clock_oe_out,
	output logic                                  xtal_enable_out,
	output logic [3:0]                            frac_high_out
);
	import rtc_pkg::*;

	logic [1:0]               rst_sync_q;
	logic                     rst_n;
	logic [31:0]              whole_q;
	logic [FRAC_W-1:0]        frac_q;
	logic [DAY_W-1:0]         day_match_q;
	logic [31:0]              reload_q;
	logic [31:0]              interval_q;
	logic                     run_q, day_en_q, int_en_q, busy_q;
	logic                     ready_q, ready_ie_q, day_flag_q, int_flag_q;
	logic [READY_CNT_W-1:0]   ready_cnt_q;
	logic                     wave_en_q, direct_rd_q, unlock_q;
	logic [1:0]               rate_q;
	logic                     bypass_q, clk_out_q, wave_q, wave_oe_q;
	logic [3:0]               osc_rsvd_q;
	logic                     osc_level, div_level, step, tick, frac_wrap;
	logic [31:0]              whole_next;
	logic                     wr, wr_whole, wr_frac, wr_day, wr_reload;
	logic                     wr_ctl, wr_osc, run_wr_ok, int_en_rise;
	logic                     int_wrap, day_hit, sync_write, mapped, wave_sel;
	logic [31:0]              ctl_view;
	logic [31:0]              rd_d;

	////////////////////////////////////////////////////////////////////////
	// Reset release
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	////////////////////////////////////////////////////////////////////////
	// Timebase
	rtc_timebase u_timebase (
		.mclk_in       (mclk_in),
		.rst_n_in      (rst_n),
		.xtal_in       (xtal_in),
		.ext_wave_in   (osc_clock_in_pin_in),
		.bypass_in     (bypass_q),
		.osc_level_out (osc_level),
		.div_level_out (div_level),
		.step_out      (step)
	);

	assign xtal_enable_out = !bypass_q;
	assign tick            = step && run_q;
	assign frac_wrap       = tick && (frac_q == FRAC_LAST);
	assign whole_next      = whole_q + 32'h1;

	////////////////////////////////////////////////////////////////////////
	// Bus decode
	assign wr        = psel_in && penable_in && pwrite_in;
	assign wr_whole  = wr && (paddr_in == OFF_WHOLE);
	assign wr_frac   = wr && (paddr_in == OFF_FRACTION);
	assign wr_day    = wr && (paddr_in == OFF_DAYTIME);
	assign wr_reload = wr && (paddr_in == OFF_INTERVAL);
	assign wr_ctl    = wr && (paddr_in == OFF_CONTROL);
	assign wr_osc    = wr && (paddr_in == OFF_CRYSTAL);
	assign run_wr_ok = wr_ctl && unlock_q;
	assign mapped    = (paddr_in == OFF_WHOLE) || (paddr_in == OFF_FRACTION)
		|| (paddr_in == OFF_DAYTIME) || (paddr_in == OFF_INTERVAL)
		|| (paddr_in == OFF_CONTROL) || (paddr_in == OFF_CRYSTAL);
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in && penable_in && !mapped;

	////////////////////////////////////////////////////////////////////////
	// Seconds and fraction counters
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			whole_q <= '0;
			frac_q  <= '0;
		end else begin
			if (wr_whole) begin
				whole_q <= pwdata_in;
			end else if (frac_wrap) begin
				whole_q <= whole_next;
			end
			if (wr_frac) begin
				frac_q <= {frac_q[FRAC_W-1:FRAC_LOW_W],
					pwdata_in[FRAC_LOW_W-1:0]};
			end else if (tick) begin
				frac_q <= frac_q + 12'h1;
			end
		end
	end

	assign frac_high_out = frac_q[FRAC_W-1:FRAC_LOW_W];

	////////////////////////////////////////////////////////////////////////
	// Alarm values and interval counter
	assign int_en_rise = wr_ctl && pwdata_in[CTL_INT_EN] && !int_en_q;
	assign int_wrap    = tick && int_en_q && (interval_q == INTERVAL_LAST);
	assign day_hit     = frac_wrap && day_en_q
		&& (whole_next[DAY_W-1:0] == day_match_q);

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			day_match_q <= '0;
			reload_q    <= '0;
			interval_q  <= '0;
		end else begin
			if (wr_day) begin
				day_match_q <= pwdata_in[DAY_W-1:0];
			end
			if (wr_reload) begin
				reload_q <= pwdata_in;
			end
			if (int_en_rise || int_wrap) begin
				interval_q <= reload_q;
			end else if (tick && int_en_q) begin
				interval_q <= interval_q + 32'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control and crystal bits reset by power-on reset only
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			run_q       <= 1'b0;
			day_en_q    <= 1'b0;
			int_en_q    <= 1'b0;
			wave_en_q   <= 1'b0;
			rate_q      <= RATE_1HZ;
			direct_rd_q <= 1'b0;
			bypass_q    <= 1'b0;
			clk_out_q   <= 1'b0;
			osc_rsvd_q  <= OSC_RSVD_RESET;
		end else begin
			if (run_wr_ok) begin
				run_q <= pwdata_in[CTL_RUN];
			end
			if (wr_ctl) begin
				day_en_q    <= pwdata_in[CTL_DAY_EN];
				int_en_q    <= pwdata_in[CTL_INT_EN];
				wave_en_q   <= pwdata_in[CTL_WAVE_EN];
				rate_q      <= pwdata_in[CTL_RATE_HI:CTL_RATE_LO];
				direct_rd_q <= pwdata_in[CTL_DIRECT_RD];
			end
			if (wr_osc) begin
				bypass_q   <= pwdata_in[OSC_BYPASS];
				clk_out_q  <= pwdata_in[OSC_CLK_OUT];
				osc_rsvd_q <= pwdata_in[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bits also cleared by soft reset; hardware set wins over a bus write clear
	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			unlock_q    <= 1'b0;
			ready_ie_q  <= 1'b0;
			ready_q     <= 1'b0;
			ready_cnt_q <= '0;
		end else if (soft_rst_in) begin
			unlock_q    <= 1'b0;
			ready_ie_q  <= 1'b0;
			ready_q     <= 1'b0;
			ready_cnt_q <= '0;
		end else begin
			if (wr_ctl) begin
				unlock_q   <= pwdata_in[CTL_UNLOCK];
				ready_ie_q <= pwdata_in[CTL_READY_IE];
			end
			if (tick) begin
				ready_q     <= 1'b1;
				ready_cnt_q <= READY_CNT_W'(READY_CYCLES - 1);
			end else begin
				if (ready_cnt_q != '0) begin
					ready_cnt_q <= ready_cnt_q - 1'b1;
				end else begin
					ready_q <= 1'b0;
				end
				if (wr_ctl && !pwdata_in[CTL_READY]) begin
					ready_q     <= 1'b0;
					ready_cnt_q <= '0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Alarm flags and busy
	assign sync_write = wr_whole || run_wr_ok
		|| (wr_ctl && ((pwdata_in[CTL_DAY_EN] != day_en_q)
		|| (pwdata_in[CTL_INT_EN] != int_en_q)));

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			day_flag_q <= 1'b0;
			int_flag_q <= 1'b0;
			busy_q     <= 1'b0;
		end else begin
			if (int_wrap) begin
				int_flag_q <= 1'b1;
			end else if (wr_ctl) begin
				int_flag_q <= pwdata_in[CTL_INT_FLAG];
			end
			if (day_hit) begin
				day_flag_q <= 1'b1;
			end else if (wr_ctl) begin
				day_flag_q <= pwdata_in[CTL_DAY_FLAG];
			end
			if (sync_write) begin
				busy_q <= 1'b1;
			end else if (step) begin
				busy_q <= 1'b0;
			end
		end
	end

	assign rtc_irq_out = (day_flag_q && day_en_q)
		|| (int_flag_q && int_en_q)
		|| (ready_q && ready_ie_q);
	assign wakeup_out = int_flag_q;

	////////////////////////////////////////////////////////////////////////
	// Square wave output
	always_comb begin
		unique case (rate_q)
			RATE_1HZ:   wave_sel = frac_q[FRAC_W-1];
			RATE_4KHZ:  wave_sel = div_level;
			default:    wave_sel = frac_q[FRAC_BIT_512HZ];
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			wave_q    <= 1'b0;
			wave_oe_q <= 1'b0;
		end else begin
			wave_q    <= clk_out_q ? osc_level : wave_sel;
			wave_oe_q <= clk_out_q || wave_en_q;
		end
	end

	assign osc_clock_out    = wave_q;
	assign osc_clock_oe_out = wave_oe_q;

	////////////////////////////////////////////////////////////////////////
	// Read data, latched in the setup phase
	assign ctl_view = {16'h0, unlock_q, direct_rd_q, 3'h0, rate_q,
		wave_en_q, int_flag_q, day_flag_q, ready_ie_q, ready_q,
		busy_q, int_en_q, day_en_q, run_q};

	always_comb begin
		rd_d = 32'h0;
		unique case (paddr_in)
			OFF_WHOLE:    rd_d = whole_q;
			OFF_FRACTION: rd_d = {24'h0, frac_q[FRAC_LOW_W-1:0]};
			OFF_DAYTIME:  rd_d = {12'h0, day_match_q};
			OFF_INTERVAL: rd_d = reload_q;
			OFF_CONTROL:  rd_d = ctl_view;
			OFF_CRYSTAL:  rd_d = {26'h0, clk_out_q, bypass_q, osc_rsvd_q};
			default:      rd_d = 32'h0;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			prdata_out <= 32'h0;
		end else if (psel_in && !penable_in) begin
			prdata_out <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n || soft_rst_in);

	chk_run_locked: assert property (
		(wr_ctl && !unlock_q) |=> $stable(run_q))
		else $error("run bit changed while locked");
	chk_frac_carry: assert property (
		(frac_wrap && !wr_whole) |=> (whole_q == $past(whole_q) + 32'h1))
		else $error("seconds did not advance on fraction wrap");
	chk_hold_stopped: assert property (
		(!run_q && !wr_whole && !wr_frac) |=> $stable(whole_q)
		&& $stable(frac_q))
		else $error("counter moved while stopped");
	chk_interval_wrap: assert property (
		int_wrap |=> int_flag_q && (interval_q == $past(reload_q)))
		else $error("interval wrap missed reload or flag");
	chk_daytime_hit: assert property (
		day_hit |=> day_flag_q ##0 rtc_irq_out)
		else $error("daytime match did not raise flag");
	chk_ready_window: assert property (
		tick |=> ready_q ##0 (ready_cnt_q == READY_CNT_W'(READY_CYCLES - 1)))
		else $error("ready window not started");
	chk_ready_irq: assert property (
		(ready_q && ready_ie_q) |-> rtc_irq_out)
		else $error("ready interrupt missing");
	chk_busy_set: assert property (
		sync_write |=> busy_q)
		else $error("busy not set by sync write");
	chk_wave_off: assert property (
		(!wave_en_q && !clk_out_q) |=> !osc_clock_oe_out)
		else $error("square wave driven while disabled");
	chk_bypass_xtal: assert property (
		bypass_q |-> !xtal_enable_out)
		else $error("crystal left on in bypass");

endmodule : rtc_counter_alarm_regs

// ==== verif/rtc_crystal_model.sv ====
// Crystal and external square wave sources for the RTC timebase pins.
// Assumes the bench starts and stops each source; a stopped one holds level.
`timescale 1ns/10ps
module rtc_crystal_model #(
	parameter int HALF_NS = 300
) (
	input  wire logic xtal_run_in,
	input  wire logic ext_run_in,
	output logic      xtal_out,
	output logic      ext_wave_out
);
	initial begin
		xtal_out = 1'h0;
		ext_wave_out = 1'h0;
		#7;
		forever begin
			#(HALF_NS);
			if (xtal_run_in) begin
				xtal_out = ~xtal_out;
			end
			if (ext_run_in) begin
				ext_wave_out = ~ext_wave_out;
			end
		end
	end
endmodule : rtc_crystal_model

// ==== verif/rtc_counter_alarm_regs_tb.sv ====
// Self-checking bench for the RTC register block.
// Assumes the crystal model on the timebase pins and a 20 MHz clock.
`timescale 1ns/10ps
module rtc_counter_alarm_regs_tb;
	import rtc_pkg::*;
	logic              mclk_in     = 1'h0;
	logic              arst_n_in   = 1'h0;
	logic              soft_rst_in = 1'h0;
	logic              psel_in     = 1'h0;
	logic              penable_in  = 1'h0;
	logic              pwrite_in   = 1'h0;
	logic [ADDR_W-1:0] paddr_in    = 8'h00;
	logic [31:0]       pwdata_in   = 32'h0;
	logic              xtal_run    = 1'h1;
	logic              ext_run     = 1'h0;
	logic              xtal_w, ext_w, pready_out, pslverr_out, rtc_irq_out;
	logic              wakeup_out, osc_clock_out, osc_clock_oe_out;
	logic              xtal_enable_out, e;
	logic [3:0]        frac_high_out;
	logic [31:0]       prdata_out, v, s, r;
	logic [11:0]       d;
	int                n_fail    = 0;
	int                cmp_count = 0;
	int                t;
	time               t0;
	logic [7:0]        offs [6] = '{OFF_WHOLE, OFF_FRACTION, OFF_DAYTIME,
		OFF_INTERVAL, OFF_CONTROL, OFF_CRYSTAL};
	int                codes [3] = '{0, 1, 3};

	always #25 mclk_in = ~mclk_in;

	rtc_crystal_model #(.HALF_NS(300)) xtal_u (.xtal_run_in(xtal_run),
		.ext_run_in(ext_run), .xtal_out(xtal_w), .ext_wave_out(ext_w));

	rtc_counter_alarm_regs dut_u (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.soft_rst_in(soft_rst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .xtal_in(xtal_w),
		.osc_clock_in_pin_in(ext_w), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.rtc_irq_out(rtc_irq_out), .wakeup_out(wakeup_out),
		.osc_clock_out(osc_clock_out), .osc_clock_oe_out(osc_clock_oe_out),
		.xtal_enable_out(xtal_enable_out), .frac_high_out(frac_high_out));

	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic in_rng(input int x, input int lo, input int hi);
		chk({31'h0, (x >= lo && x <= hi)}, 32'h1);
	endtask : in_rng

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : wait_cyc

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] dat, output logic [31:0] q, output logic er);
		@(posedge mclk_in);
		#1;
		psel_in = 1'h1;
		penable_in = 1'h0;
		pwrite_in = w;
		paddr_in = a;
		pwdata_in = dat;
		@(posedge mclk_in);
		#1;
		penable_in = 1'h1;
		@(posedge mclk_in);
		q = prdata_out;
		er = pslverr_out;
		#1;
		psel_in = 1'h0;
		penable_in = 1'h0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		logic [31:0] q;
		logic        er;
		bus(1'h1, a, dat, q, er);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic er;
		bus(1'h0, a, 32'h0, q, er);
	endtask : rd

	task automatic wait_busy();
		logic [31:0] q;
		for (int i = 0; i < 400; i++) begin
			rd(OFF_CONTROL, q);
			if (q[CTL_BUSY] === 1'h0) return;
		end
		n_fail++;
		test_done();
	endtask : wait_busy

	task automatic wait_flag();
		for (int i = 0; i < 2000; i++) begin
			wait_cyc(1);
			if (wakeup_out === 1'h1) return;
		end
		n_fail++;
		test_done();
	endtask : wait_flag

	task automatic frac_now(output logic [11:0] f);
		logic [31:0] q;
		rd(OFF_FRACTION, q);
		f = {frac_high_out, q[7:0]};
	endtask : frac_now

	task automatic count_toggles(input int n, output int c);
		logic p;
		c = 0;
		p = osc_clock_out;
		repeat (n) begin
			wait_cyc(1);
			if (osc_clock_out !== p) c++;
			p = osc_clock_out;
		end
	endtask : count_toggles

	////////////////////////////////////////////////////////////////////////
	initial begin
		#(100000 * 50);
		n_fail++;
		test_done();
	end

	initial begin
		void'($urandom(32'h2732DBBF));
		wait_cyc(20);
		arst_n_in = 1'h1;
		wait_cyc(3);
		// Reset values and unmapped access
		foreach (offs[i]) begin
			rd(offs[i], v);
			chk(v, (i == 5) ? {28'h0, OSC_RSVD_RESET} : 32'h0);
		end
		chk({frac_high_out, pready_out, rtc_irq_out, wakeup_out,
			osc_clock_oe_out, xtal_enable_out}, 32'h11);
		bus(1'h0, 8'h14, 32'h0, v, e);
		chk({e, v[30:0]}, 32'h80000000);
		// Random register contents
		r = $urandom();
		wr(OFF_DAYTIME, r);
		rd(OFF_DAYTIME, v);
		chk(v, r & 32'h000FFFFF);
		r = $urandom();
		wr(OFF_INTERVAL, r);
		rd(OFF_INTERVAL, v);
		chk(v, r);
		r = $urandom();
		wr(OFF_FRACTION, r);
		rd(OFF_FRACTION, v);
		chk(v, r & 32'hFF);
		s = $urandom();
		wr(OFF_WHOLE, s);
		rd(OFF_CONTROL, v);
		chk(v & 32'h8, 32'h8);
		wait_busy();
		rd(OFF_WHOLE, v);
		chk(v, s);
		// Run bit lock
		wr(OFF_CONTROL, 32'h1);
		wait_busy();
		rd(OFF_CONTROL, v);
		chk(v & 32'h1, 32'h0);
		wr(OFF_CONTROL, 32'hC000);
		wait_busy();
		wr(OFF_CONTROL, 32'hC001);
		wait_busy();
		rd(OFF_CONTROL, v);
		chk(v & 32'hC001, 32'hC001);
		// Fraction advance and ready
		frac_now(d);
		r = {20'h0, d};
		wait_cyc(960);
		frac_now(d);
		in_rng(int'(d - r[11:0]), 9, 11);
		rd(OFF_WHOLE, v);
		chk(v, s);
		rd(OFF_CONTROL, v);
		chk(v & 32'h10, 32'h10);
		wr(OFF_CONTROL, 32'hC031);
		wait_cyc(2);
		chk({31'h0, rtc_irq_out}, 32'h1);
		soft_rst_in = 1'h1;
		wait_cyc(1);
		soft_rst_in = 1'h0;
		rd(OFF_CONTROL, v);
		chk(v & 32'h8021, 32'h1);
		chk({31'h0, rtc_irq_out}, 32'h0);
		// Timebase stopped: ready expires, wave follows fraction bits
		wait_cyc(100);
		xtal_run = 1'h0;
		wait_cyc(100);
		rd(OFF_CONTROL, v);
		chk(v & 32'h10, 32'h10);
		wait_cyc(2500);
		rd(OFF_CONTROL, v);
		chk(v & 32'h10, 32'h0);
		rd(OFF_FRACTION, r);
		foreach (codes[i]) begin
			wr(OFF_CONTROL, 32'h101 | (codes[i] << 9));
			wait_cyc(3);
			chk({osc_clock_oe_out, osc_clock_out},
				{1'h1, (i == 0) ? frac_high_out[3] : r[2]});
		end
		wr(OFF_CONTROL, 32'h1);
		wait_cyc(3);
		chk({31'h0, osc_clock_oe_out}, 32'h0);
		xtal_run = 1'h1;
		wr(OFF_CONTROL, 32'h501);
		count_toggles(960, t);
		in_rng(t, 19, 21);
		wr(OFF_CRYSTAL, 32'h29);
		count_toggles(960, t);
		in_rng(t, 159, 161);
		wr(OFF_CRYSTAL, 32'h09);
		// Interval alarm with auto reload
		wr(OFF_CONTROL, 32'h1);
		wr(OFF_INTERVAL, 32'hFFFFFFFD);
		t0 = $time;
		wr(OFF_CONTROL, 32'h5);
		wait_busy();
		wait_flag();
		in_rng(int'(($time - t0) / 50), 90, 420);
		t0 = $time;
		rd(OFF_CONTROL, v);
		chk(v & 32'h80, 32'h80);
		chk({31'h0, rtc_irq_out}, 32'h1);
		wr(OFF_CONTROL, 32'h5);
		wait_cyc(1);
		chk({31'h0, wakeup_out}, 32'h0);
		wait_flag();
		in_rng(int'(($time - t0) / 50), 285, 291);
		wr(OFF_CONTROL, 32'h1);
		wait_busy();
		chk({31'h0, rtc_irq_out}, 32'h0);
		// Daytime flag gated by its enable
		wr(OFF_CONTROL, 32'h43);
		wait_busy();
		chk({31'h0, rtc_irq_out}, 32'h1);
		wr(OFF_CONTROL, 32'h41);
		wait_busy();
		chk({31'h0, rtc_irq_out}, 32'h0);
		rd(OFF_CONTROL, v);
		chk(v & 32'h40, 32'h40);
		wr(OFF_CONTROL, 32'h1);
		// Bypass to the external wave
		wr(OFF_CRYSTAL, 32'h19);
		wait_cyc(2);
		chk({31'h0, xtal_enable_out}, 32'h0);
		xtal_run = 1'h0;
		ext_run = 1'h1;
		frac_now(d);
		r = {20'h0, d};
		wait_cyc(480);
		frac_now(d);
		in_rng(int'(d - r[11:0]), 4, 6);
		// Run cleared holds the counts
		wr(OFF_CONTROL, 32'h8001);
		wait_busy();
		wr(OFF_CONTROL, 32'h8000);
		wait_busy();
		rd(OFF_FRACTION, r);
		wait_cyc(500);
		rd(OFF_FRACTION, v);
		chk(v, r);
		test_done();
	end
endmodule : rtc_counter_alarm_regs_tb
